// file: include/ais_regs.vh
`ifndef AIS_REGS_VH
`define AIS_REGS_VH

// ***************************************************************
// Register addresses and pages
// ***************************************************************
`define AIS_PAGE_MAIN       4'h0
`define AIS_PAGE_TRIM       4'hF
`define AIS_ADDR_CHSEL      8'hBB
`define AIS_ADDR_REFCTL     8'hD1
`define AIS_ADDR_OFS_HIGH   8'h86
`define AIS_ADDR_OFS_LOW    8'h85

// ***************************************************************
// Reset values
// ***************************************************************
`define AIS_CHSEL_RST       5'h1F
`define AIS_ONEHOT_RST      32'h80000000
`define AIS_REFCTL_RST      8'h18
`define AIS_RDATA_RST       8'h00
`define AIS_TRIM_RST        10'h000

// ***************************************************************
// Field layouts
// ***************************************************************
`define AIS_CHSEL_CODE      4:0
`define AIS_CHSEL_PAD       3'h0
`define AIS_REFCTL_MASK     8'h3D
`define AIS_REFCTL_TSEN     2
`define AIS_REFCTL_GND      5
`define AIS_REFCTL_SEL      4:3
`define AIS_REFCTL_OE       0
`define AIS_OFS_HIGH_BITS   9:2
`define AIS_OFS_LOW_BITS    1:0
`define AIS_OFS_LOW_PAD     6'h00
`define AIS_SEL_P0_BITS     7:0
`define AIS_SEL_P1_BITS     15:8
`define AIS_SEL_P2_BITS     22:16

// ***************************************************************
// Channel codes
// ***************************************************************
`define AIS_CODE_P1_7       5'h0F
`define AIS_CODE_P2_FIRST   5'h10
`define AIS_CODE_P2_LAST    5'h16
`define AIS_CODE_RSV_FIRST  5'h17
`define AIS_CODE_RSV_LAST   5'h1A
`define AIS_CODE_TEMP       5'h1B
`define AIS_CODE_VBAT       5'h1C
`define AIS_CODE_VREG       5'h1D
`define AIS_CODE_VDD        5'h1E
`define AIS_CODE_GND        5'h1F
`define AIS_NUM_CODES       32

// ***************************************************************
// Trim capture timing
// ***************************************************************
`define AIS_TRIM_SETTLE     2'h2

`endif

// file: hw/ais_trim_hold.v
`include "ais_regs.vh"

module ais_trim_hold (
  // Clock, reset, enable
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // Factory pins
  input  wire [9:0] trim_pin,
  input  wire       large_pkg_pin,
  // Captured values
  output reg  [9:0] trim_r,
  output reg        large_r,
  output reg        loaded_r
);

  reg  [9:0] trim_s1_r;
  reg  [9:0] trim_s2_r;
  reg        large_s1_r;
  reg        large_s2_r;
  reg  [1:0] settle_r;

  // ***************************************************************
  // Two-stage synchronisers for the fuse and strap lines
  // ***************************************************************
  always @(posedge clk) begin
    if (rst) begin
      trim_s1_r  <= `AIS_TRIM_RST;
      trim_s2_r  <= `AIS_TRIM_RST;
      large_s1_r <= 1'b0;
      large_s2_r <= 1'b0;
    end else if (ce) begin
      trim_s1_r  <= trim_pin;
      trim_s2_r  <= trim_s1_r;
      large_s1_r <= large_pkg_pin;
      large_s2_r <= large_s1_r;
    end
  end

  // ***************************************************************
  // One-shot capture after release
  // ***************************************************************
  // Fuses are static; capture once so later glitches cannot alter the value
  always @(posedge clk) begin
    if (rst) begin
      settle_r <= 2'h0;
      trim_r   <= `AIS_TRIM_RST;
      large_r  <= 1'b0;
      loaded_r <= 1'b0;
    end else if (ce && !loaded_r) begin
      if (settle_r == `AIS_TRIM_SETTLE) begin
        trim_r   <= trim_s2_r;
        large_r  <= large_s2_r;
        loaded_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 2'h1;
      end
    end
  end

endmodule // ais_trim_hold

// file: hw/ais_top.v
`include "ais_regs.vh"

module ais_top (
  // Clock, reset, enable
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // Special-function-register bus
  input  wire [3:0] sfr_page,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  // Factory pins
  input  wire [9:0] trim_pin,
  input  wire       large_pkg_pin,
  // Analog mux selection
  output reg  [4:0] positive_input_code,
  output wire [7:0] sel_port0,
  output wire [7:0] sel_port1,
  output wire [6:0] sel_port2,
  output wire       sel_temp,
  output wire       sel_vbat,
  output wire       sel_vreg,
  output wire       sel_vdd,
  output wire       sel_gnd,
  output wire       sel_none,
  // Reference control and sensor
  output wire       temp_sensor_enable,
  output wire       ref_ground_pin,
  output wire [1:0] ref_select,
  output wire       ref_precision_en,
  output reg        temp_sample_ok,
  output wire       trim_loaded
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  reg  [4:0]                  code_nxt;
  reg  [7:0]                  refctl_r;
  reg  [7:0]                  refctl_nxt;
  reg  [`AIS_NUM_CODES-1:0]   onehot_r;
  wire [`AIS_NUM_CODES-1:0]   onehot_nxt;
  reg  [7:0]                  rdata_nxt;
  wire [9:0]                  temp_offset_value;
  wire                        large_pkg;
  wire                        hit_chsel;
  wire                        hit_refctl;
  wire                        hit_ofs_high;
  wire                        hit_ofs_low;
  reg                         none_r;

  // ***************************************************************
  // Factory offset and package strap
  // ***************************************************************
  // Fuses and strap pass three flops in there before anything here reads them
  ais_trim_hold ais_trim_hold_inst (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .trim_pin      (trim_pin),
    .large_pkg_pin (large_pkg_pin),
    .trim_r        (temp_offset_value),
    .large_r       (large_pkg),
    .loaded_r      (trim_loaded)
  );

  // ***************************************************************
  // Address decode
  // ***************************************************************
  // Page and address both take part so trim bytes do not alias page 0
  // Both writable registers sit on the main page; the trim page is read-only
  assign hit_chsel     = (sfr_page == `AIS_PAGE_MAIN) && (sfr_addr == `AIS_ADDR_CHSEL);
  assign hit_refctl    = (sfr_page == `AIS_PAGE_MAIN) && (sfr_addr == `AIS_ADDR_REFCTL);
  assign hit_ofs_high  = (sfr_page == `AIS_PAGE_TRIM) && (sfr_addr == `AIS_ADDR_OFS_HIGH);
  assign hit_ofs_low   = (sfr_page == `AIS_PAGE_TRIM) && (sfr_addr == `AIS_ADDR_OFS_LOW);

  // ***************************************************************
  // Register write path
  // ***************************************************************
  // Trim bytes have no write path at all, so writes there fall away
  // Ground-before-sensor ordering is left to software; any code is taken
  always @* begin
    code_nxt   = positive_input_code;
    refctl_nxt = refctl_r;
    if (sfr_wr && hit_chsel) begin
      code_nxt = sfr_wdata[`AIS_CHSEL_CODE];
    end
    if (sfr_wr && hit_refctl) begin
      refctl_nxt = sfr_wdata & `AIS_REFCTL_MASK;
    end
  end

  // Channel and reference control storage
  always @(posedge clk) begin
    if (rst) begin
      positive_input_code <= `AIS_CHSEL_RST;
      refctl_r            <= `AIS_REFCTL_RST;
    end else if (ce) begin
      positive_input_code <= code_nxt;
      refctl_r            <= refctl_nxt;
    end
  end

  // ***************************************************************
  // Reference control outputs
  // ***************************************************************
  // Each field drives its pin straight from the register flops
  assign temp_sensor_enable = refctl_r[`AIS_REFCTL_TSEN];
  assign ref_ground_pin     = refctl_r[`AIS_REFCTL_GND];
  assign ref_select         = refctl_r[`AIS_REFCTL_SEL];
  assign ref_precision_en   = refctl_r[`AIS_REFCTL_OE];

  // ***************************************************************
  // Channel decode, one flop per code
  // ***************************************************************
  // Decoded from the next code so the mux follows a write in one cycle
  genvar gi;
  generate
    for (gi = 0; gi < `AIS_NUM_CODES; gi = gi + 1) begin : g_code
      localparam [31:0] IDX_W = gi;
      localparam [4:0]  IDX   = IDX_W[4:0];
      localparam       BIG = (IDX == `AIS_CODE_P1_7) ||
                             ((IDX >= `AIS_CODE_P2_FIRST) && (IDX <= `AIS_CODE_P2_LAST));
      localparam       RSV = (IDX >= `AIS_CODE_RSV_FIRST) && (IDX <= `AIS_CODE_RSV_LAST);
      // Small packages lack the upper pins; reserved codes switch nothing
      assign onehot_nxt[gi] = (code_nxt == IDX) && !RSV &&
                              (large_pkg || !BIG);
    end
  endgenerate

  // ***************************************************************
  // Registered selection lines
  // ***************************************************************
  // Reset lands on ground like the code register, so the input does not float out of reset
  always @(posedge clk) begin
    if (rst) begin
      onehot_r <= `AIS_ONEHOT_RST;
      none_r   <= 1'b0;
    end else if (ce) begin
      onehot_r <= onehot_nxt;
      none_r   <= ~|onehot_nxt;
    end
  end

  // ***************************************************************
  // Selection outputs
  // ***************************************************************
  // Straight from flops so the analog switches see no decode glitches
  assign sel_port0 = onehot_r[`AIS_SEL_P0_BITS];
  assign sel_port1 = onehot_r[`AIS_SEL_P1_BITS];
  assign sel_port2 = onehot_r[`AIS_SEL_P2_BITS];
  assign sel_temp  = onehot_r[`AIS_CODE_TEMP];
  assign sel_vbat  = onehot_r[`AIS_CODE_VBAT];
  assign sel_vreg  = onehot_r[`AIS_CODE_VREG];
  assign sel_vdd   = onehot_r[`AIS_CODE_VDD];
  assign sel_gnd   = onehot_r[`AIS_CODE_GND];
  // Nothing selected: reserved code, or a large-only pin on a small package
  assign sel_none  = none_r;

  // ***************************************************************
  // Temperature sample qualifier
  // ***************************************************************
  // A conversion on the sensor only means something while it is powered
  // Built from next values so the flag moves together with sel_temp
  always @(posedge clk) begin
    if (rst) begin
      temp_sample_ok <= 1'b0;
    end else if (ce) begin
      temp_sample_ok <= onehot_nxt[`AIS_CODE_TEMP] &
                        refctl_nxt[`AIS_REFCTL_TSEN];
    end
  end

  // ***************************************************************
  // Register read path
  // ***************************************************************
  // Unmapped addresses read zero; data is held until the next read
  // A read sharing a cycle with a write returns the old value
  always @* begin
    rdata_nxt = sfr_rdata;
    if (sfr_rd) begin
      if (hit_chsel) begin
        rdata_nxt = {`AIS_CHSEL_PAD, positive_input_code};
      end else if (hit_refctl) begin
        rdata_nxt = refctl_r;
      end else if (hit_ofs_high) begin
        rdata_nxt = temp_offset_value[`AIS_OFS_HIGH_BITS];
      end else if (hit_ofs_low) begin
        rdata_nxt = {temp_offset_value[`AIS_OFS_LOW_BITS], `AIS_OFS_LOW_PAD};
      end else begin
        rdata_nxt = `AIS_RDATA_RST;
      end
    end
  end

  // ***************************************************************
  // Read data register
  // ***************************************************************
  // Held between reads so software may pick the byte up late
  always @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= `AIS_RDATA_RST;
    end else if (ce) begin
      sfr_rdata <= rdata_nxt;
    end
  end

endmodule // ais_top

// file: sim/ais_chk_assertions.sv
module ais_chk (
  // Clock and control
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  // Register bus
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Selection outputs
  input wire logic [4:0] positive_input_code,
  input wire logic       sel_temp,
  input wire logic       sel_gnd,
  input wire logic       sel_none,
  input wire logic       temp_sensor_enable,
  input wire logic       temp_sample_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Channel register strobes
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Only a taken write may move the code, so ce is part of the strobe
  wire       wc = ce && sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hBB;
  wire       rc = ce && sfr_rd && !sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hBB;
  wire [4:0] wv = sfr_wdata[4:0];
  property p_wr_code;
    wc |=> positive_input_code == $past(wv);
  endproperty
  a_wr_code: assert property (p_wr_code) else $error("code not taken");
  property p_rd_code;
    rc |=> sfr_rdata == {3'h0, $past(positive_input_code)};
  endproperty
  a_rd_code: assert property (p_rd_code) else $error("code readback wrong");
  property p_hold;
    !wc |=> $stable(positive_input_code);
  endproperty
  a_hold: assert property (p_hold) else $error("code moved without write");
  property p_gnd;
    wc && wv == 5'h1F |=> sel_gnd && !sel_temp && !sel_none;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground not selected");
  property p_temp;
    wc && wv == 5'h1B |=> sel_temp && !sel_gnd && !sel_none;
  endproperty
  a_temp: assert property (p_temp) else $error("sensor not selected");
  property p_rsv;
    wc && wv inside {[5'h17:5'h1A]} |=> sel_none && !sel_temp && !sel_gnd;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code selects a source");
  property p_tok;
    (ce && sel_temp && temp_sensor_enable)[*2] |-> temp_sample_ok;
  endproperty
  a_tok: assert property (p_tok) else $error("sensor sample not flagged");
  property p_ofs_low;
    ce && sfr_rd && sfr_page == 4'hF && sfr_addr == 8'h85 |=> sfr_rdata[5:0] == 6'h00;
  endproperty
  a_ofs_low: assert property (p_ofs_low) else $error("offset low pad not zero");
endmodule // ais_chk

bind ais_top ais_chk ais_chk_inst (.clk(clk), .rst(rst), .ce(ce), .sfr_page(sfr_page),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .positive_input_code(positive_input_code), .sel_temp(sel_temp),
  .sel_gnd(sel_gnd), .sel_none(sel_none), .temp_sensor_enable(temp_sensor_enable),
  .temp_sample_ok(temp_sample_ok));

// file: sim/ais_top_tb.sv
module ais_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs, all valued at time zero
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, big = 1'b1;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [9:0] trim_pin = 10'h2B5;
  // Design outputs
  wire  [7:0] sfr_rdata, sel_port0, sel_port1;
  wire  [6:0] sel_port2;
  wire  [4:0] positive_input_code;
  wire        sel_temp, sel_vbat, sel_vreg, sel_vdd, sel_gnd, sel_none, tse, tso, rgp, rpe, tld;
  wire  [1:0] rsel;
  wire [28:0] sel_all = {sel_none, sel_gnd, sel_vdd, sel_vreg, sel_vbat, sel_temp,
                         sel_port2, sel_port1, sel_port0};
  int         err_count = 0, n_checks = 0;

  ais_top ais_top_inst (
    .clk(clk), .rst(rst), .ce(ce), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .trim_pin(trim_pin), .large_pkg_pin(big), .positive_input_code(positive_input_code),
    .sel_port0(sel_port0), .sel_port1(sel_port1), .sel_port2(sel_port2),
    .sel_temp(sel_temp), .sel_vbat(sel_vbat), .sel_vreg(sel_vreg), .sel_vdd(sel_vdd),
    .sel_gnd(sel_gnd), .sel_none(sel_none), .temp_sensor_enable(tse), .ref_ground_pin(rgp),
    .ref_select(rsel), .ref_precision_en(rpe), .temp_sample_ok(tso), .trim_loaded(tld)
  );

  // ****
  // Clock and bus tasks
  // ****
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(string s, logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Strobes are one-cycle pulses; effects are settled 1 ns after the taking edge
  task automatic bus(logic w, logic [3:0] pg, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    sfr_page <= pg;
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= !w;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask
  // Package strap is captured only after reset, so a change needs a new reset
  task automatic do_reset(logic b);
    @(posedge clk);
    rst <= 1'b1;
    big <= b;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("gnd_in_reset", sel_all, exp_sel(31));
    @(posedge clk);
    #1;
    chk("trim_early", tld, 1'b0);
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] exp_sel(int c);
    if (c >= 23 && c <= 26) return 32'h1 << 28;
    return 32'h1 << (c < 23 ? c : c - 4);
  endfunction
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset(1'b1);
    bus(1'b0, 4'h0, 8'hBB, 8'h00);
    chk("chsel_rst", sfr_rdata, 8'h1F);
    chk("gnd_rst", sel_gnd, 1'b1);
    chk("trim_loaded", tld, 1'b1);
    bus(1'b0, 4'h0, 8'hD1, 8'h00);
    chk("refctl_rst", sfr_rdata, 8'h18);
    bus(1'b1, 4'h0, 8'hBB, 8'hE5);
    bus(1'b0, 4'h0, 8'hBB, 8'h00);
    chk("chsel_pad", sfr_rdata, 8'h05);
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, 4'h0, 8'hBB, 8'(c));
      chk("sel_all", sel_all, exp_sel(c));
    end
    // Clock enable low: a write is not taken and the mux stays put
    @(posedge clk);
    ce <= 1'b0;
    bus(1'b1, 4'h0, 8'hBB, 8'h05);
    @(posedge clk);
    ce <= 1'b1;
    bus(1'b0, 4'h0, 8'hBB, 8'h00);
    chk("ce_frozen", sfr_rdata, 8'h1F);
    chk("ce_sel", sel_gnd, 1'b1);
    // Reference control: unused bits stay zero, fields reach their pins
    bus(1'b1, 4'h0, 8'hD1, 8'hFF);
    bus(1'b0, 4'h0, 8'hD1, 8'h00);
    chk("refctl_mask", sfr_rdata, 8'h3D);
    chk("ref_pins", {rgp, rsel, rpe, tse}, 5'h1F);
    // Sensor on, then ground before the sensor channel
    bus(1'b1, 4'h0, 8'hD1, 8'h1C);
    bus(1'b1, 4'h0, 8'hBB, 8'h1F);
    bus(1'b1, 4'h0, 8'hBB, 8'h1B);
    repeat (2) @(posedge clk);
    #1;
    chk("tse", tse, 1'b1);
    chk("temp_ok", tso, 1'b1);
    chk("ref_pins_on", {rgp, rsel, rpe, tse}, 5'h0D);
    bus(1'b1, 4'h0, 8'hD1, 8'h18);
    repeat (2) @(posedge clk);
    #1;
    chk("temp_off", tso, 1'b0);
    chk("tse_off", tse, 1'b0);
    // Offset registers ignore writes and show the pins unchanged
    bus(1'b1, 4'hF, 8'h86, 8'h00);
    bus(1'b1, 4'hF, 8'h85, 8'hFF);
    bus(1'b0, 4'hF, 8'h86, 8'h00);
    chk("ofs_high", sfr_rdata, 8'hAD);
    bus(1'b0, 4'hF, 8'h85, 8'h00);
    chk("ofs_low", sfr_rdata, 8'h40);
    bus(1'b0, 4'h0, 8'h00, 8'h00);
    chk("unmapped", sfr_rdata, 8'h00);
    // Small package: large-only codes connect nothing
    do_reset(1'b0);
    bus(1'b1, 4'h0, 8'hBB, 8'h0F);
    chk("p17_small", sel_none, 1'b1);
    bus(1'b1, 4'h0, 8'hBB, 8'h10);
    chk("p20_small", sel_none, 1'b1);
    bus(1'b1, 4'h0, 8'hBB, 8'h0E);
    chk("p16_small", sel_all, exp_sel(14));
    bus(1'b1, 4'h0, 8'hBB, 8'h16);
    chk("p26_small", sel_none, 1'b1);
    stop_test;
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule // ais_top_tb
